//--- acc_dev.sv
/*
  acc_dev: conversion controller, the converter's end of the link.
  Assumes the modulator/filter delivers a sample on I_SAMPLE at each completion,
  and software drives control writes through the acc_if sw modport.
*/
`timescale 1ns/1ns
module acc_dev (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  acc_if.dev bus,
  input wire logic [10:0] I_SAMPLE,
  output logic O_PWR_ON,
  output logic O_REF_OUT_EN,
  output logic [1:0] O_REF_LEVEL,
  output logic [3:0] O_CHANNEL,
  output logic O_ANALOG_MODE,
  output logic O_DONE
);
  acc_pkg::acc_state_t state;
  logic [7:0] ctrl;
  logic ref_hi;
  logic [acc_pkg::CNT_W-1:0] cnt;
  logic [7:0] idle_cnt;
  logic powered;
  logic done;
  logic irq;
  logic f_valid;
  logic f_ready;
  logic [10:0] f_data;
  logic en_wr;
  logic continuous_select;

  assign en_wr = bus.ctrl_wr && bus.ctrl_wdata[acc_pkg::BIT_EN];
  assign continuous_select = ctrl[acc_pkg::BIT_CONTINUOUS_SELECT];

  // conversion sequencer
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state <= acc_pkg::ACC_IDLE;
      cnt <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (en_wr)
      begin
        // a fresh enable restarts whatever is running
        // a restart caught mid power-up counts the whole power-up again
        state <= (powered && state != acc_pkg::ACC_PWRUP) ? acc_pkg::ACC_FIRST :
          acc_pkg::ACC_PWRUP;
        cnt <= '0;
      end
      else
      begin
        case (state)
          acc_pkg::ACC_PWRUP:
          begin
            if (cnt == acc_pkg::CNT_W'(acc_pkg::POWERUP_CYC - 1))
            begin
              state <= acc_pkg::ACC_FIRST;
              cnt <= '0;
            end
            else
            begin
              cnt <= cnt + 1'b1;
            end
          end
          acc_pkg::ACC_FIRST:
          begin
            if (cnt == acc_pkg::CNT_W'(acc_pkg::FIRST_CONV_CYC - 1))
            begin
              done <= 1'b1;
              cnt <= '0;
              state <= continuous_select ? acc_pkg::ACC_CONTINUOUS_SELECT : acc_pkg::ACC_IDLE;
            end
            else
            begin
              cnt <= cnt + 1'b1;
            end
          end
          acc_pkg::ACC_CONTINUOUS_SELECT:
          begin
            if (cnt == acc_pkg::CNT_W'(acc_pkg::NEXT_CONV_CYC - 1))
            begin
              // a cleared select ends the run when the one in flight is due, with no done for it
              done <= continuous_select;
              cnt <= '0;
              if (!continuous_select)
              begin
                state <= acc_pkg::ACC_IDLE;
              end
            end
            else
            begin
              cnt <= cnt + 1'b1;
            end
          end
          default:
          begin
            state <= acc_pkg::ACC_IDLE;
            cnt <= '0;
          end
        endcase
      end
    end
  end

  // control register; all fields taken in one write
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      ctrl <= acc_pkg::CTRL_RST;
    end
    else
    begin
      if (bus.ctrl_wr)
      begin
        // writing zero to enable has no effect on a running conversion
        ctrl <= {bus.ctrl_wdata[acc_pkg::BIT_EN] | ctrl[acc_pkg::BIT_EN],
          bus.ctrl_wdata[acc_pkg::BIT_EN-1:0]};
      end
      // done rises on the same edge as the state change, so it alone marks completion;
      // later completions of a run find the bit low already and keep it there
      if (done)
      begin
        ctrl[acc_pkg::BIT_EN] <= 1'b0;
      end
      if (en_wr)
      begin
        ctrl[acc_pkg::BIT_EN] <= 1'b1;
      end
    end
  end

  // high bit of the reference pair lives in the second register
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      ref_hi <= acc_pkg::REF_HI_RST;
    end
    else if (bus.ref_hi_wr)
    begin
      ref_hi <= bus.ref_hi_wdata;
    end
  end

  // automatic powerdown after a long idle stretch
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      idle_cnt <= '0;
      powered <= 1'b0;
    end
    else if (state != acc_pkg::ACC_IDLE || en_wr)
    begin
      idle_cnt <= '0;
      powered <= (state != acc_pkg::ACC_PWRUP) || powered || 
        (cnt == acc_pkg::CNT_W'(acc_pkg::POWERUP_CYC - 1));
    end
    else if (idle_cnt == 8'(acc_pkg::IDLE_PD_CYC - 1))
    begin
      powered <= 1'b0;
    end
    else
    begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // results queue so a slow reader does not stall sampling
  acc_fifo #(.WIDTH(acc_pkg::RES_W), .DEPTH(acc_pkg::FIFO_DEPTH)) u_fifo (
    .I_CLK(I_CLK),
    .I_RST_B(I_RST_B),
    .i_in_valid(done),
    .o_in_ready(),
    .i_in_data(I_SAMPLE),
    .o_out_valid(f_valid),
    .i_out_ready(f_ready),
    .o_out_data(f_data)
  );
  assign f_ready = 1'b1;

  // newest result overwrites the data bytes
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      bus.res_hi <= 8'h00;
      bus.res_lo <= 8'h00;
    end
    else if (f_valid)
    begin
      bus.res_hi <= f_data[10:3];
      bus.res_lo <= {f_data[2:0], 5'h00};
    end
  end

  // interrupt: set wins over ack, only while powered, kept when disabled
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      irq <= 1'b0;
    end
    else if (done && powered)
    begin
      irq <= 1'b1;
    end
    else if (bus.irq_ack)
    begin
      irq <= 1'b0; // disabling alone never clears it
    end
  end
  assign bus.irq = irq;
  assign bus.ctrl_rdata = ctrl;

  // outputs toward the analog side, all registered
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_PWR_ON <= 1'b0;
      O_REF_OUT_EN <= 1'b0;
      O_REF_LEVEL <= acc_pkg::REF_2V0;
      O_CHANNEL <= 4'h0;
      O_ANALOG_MODE <= 1'b0;
      O_DONE <= 1'b0;
    end
    else
    begin
      O_PWR_ON <= powered;
      O_REF_OUT_EN <= ctrl[acc_pkg::BIT_REFOUT];
      O_REF_LEVEL <= {ref_hi, ctrl[acc_pkg::BIT_REFLO]};
      O_CHANNEL <= ctrl[acc_pkg::CH_HI:0];
      O_ANALOG_MODE <= (state != acc_pkg::ACC_IDLE);
      O_DONE <= done;
    end
  end
endmodule

//--- acc_pkg.sv
/*
  acc_pkg: constants shared by the conversion controller and its software-side end.
  Assumes a single 100 MHz system clock and an active-low asynchronous reset.
*/
// Overview of operation
// - each new result overwrites the previous one
// - every finished conversion raises an interrupt request
// - first conversion 5129 cycles, plus 40 powerup
// - enable clears after first, stays zero
// - continuous mode: new result every 256 cycles
// - 11-bit result split high byte, low 7:5
// - software stops continuous by clearing select
// - interrupt only while converter powered
// - disabling keeps an already pending interrupt
// - software sets continuous select to start
// - software writes enable one to launch
// - all control fields written in one write
// - reference output only with internal reference
// - reference level: high bit elsewhere, low here
// - control register fields and zero reset
// - analog pins drop digital drivers
// - enable one restarts, enable zero ignored
// - reference code 00 ext, 01 1V, 10 2V
// - idle 160 cycles powers down, 40 up
// - single shot: one conversion, clear, stop
package acc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int FIRST_CONV_CYC = 5129;
  localparam int NEXT_CONV_CYC = 256;
  localparam int POWERUP_CYC = 40;
  localparam int IDLE_PD_CYC = 160;
  localparam int CNT_W = 13;
  localparam int RES_W = 11;
  localparam int FIFO_DEPTH = 8;
  // control register 0 layout
  localparam int BIT_EN = 7;
  localparam int BIT_REFLO = 6;
  localparam int BIT_REFOUT = 5;
  localparam int BIT_CONTINUOUS_SELECT = 4;
  localparam int CH_HI = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_1V0 = 2'h1;
  localparam logic [1:0] REF_2V0 = 2'h2;
  localparam logic REF_HI_RST = 1'h1;
  typedef enum logic [3:0] {
    ACC_IDLE = 4'h1,
    ACC_PWRUP = 4'h2,
    ACC_FIRST = 4'h4,
    ACC_CONTINUOUS_SELECT = 4'h8
  } acc_state_t;
endpackage

//--- acc_if.sv
/*
  acc_if: carrier between the software-side end and the converter controller.
  Assumes both ends share one clock; the testbench joins them.
*/
`timescale 1ns/1ns
interface acc_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic ref_hi_wr;
  logic ref_hi_wdata;
  logic [7:0] ctrl_rdata;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic irq;
  logic irq_ack;
  modport dev (input ctrl_wr, ctrl_wdata, ref_hi_wr, ref_hi_wdata, irq_ack,
    output ctrl_rdata, res_hi, res_lo, irq);
  modport sw (output ctrl_wr, ctrl_wdata, ref_hi_wr, ref_hi_wdata, irq_ack,
    input ctrl_rdata, res_hi, res_lo, irq);
endinterface

//--- acc_fifo.sv
/*
  acc_fifo: small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; DEPTH a power of two.
*/
`timescale 1ns/1ns
module acc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // full and empty come straight from the extra pointer bit
  assign o_in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage has no reset, only pointers matter
  always_ff @(posedge I_CLK)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  // pointer update
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

//--- acc_sw.sv
/*
  acc_sw: software-side end; turns user requests into control writes.
  Assumes the user pulses one request at a time.
*/
`timescale 1ns/1ns
module acc_sw (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  acc_if.sw bus,
  input wire logic I_START,
  input wire logic I_STOP,
  input wire logic I_CONTINUOUS_SELECT,
  input wire logic [3:0] I_CHANNEL,
  input wire logic [1:0] I_REF_LEVEL,
  input wire logic I_REF_OUT,
  input wire logic I_ACK,
  output logic [10:0] O_RESULT,
  output logic O_IRQ
);
  logic [7:0] last;

  // one write carries every field
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      bus.ctrl_wr <= 1'b0;
      bus.ctrl_wdata <= acc_pkg::CTRL_RST;
      bus.ref_hi_wr <= 1'b0;
      bus.ref_hi_wdata <= acc_pkg::REF_HI_RST;
      last <= acc_pkg::CTRL_RST;
    end
    else
    begin
      bus.ctrl_wr <= I_START || I_STOP;
      bus.ref_hi_wr <= I_START;
      bus.ref_hi_wdata <= I_REF_LEVEL[1];
      if (I_START)
      begin
        // reference output only with internal reference on
        bus.ctrl_wdata <= {1'b1, I_REF_LEVEL[0],
          I_REF_OUT && (I_REF_LEVEL != acc_pkg::REF_EXT), I_CONTINUOUS_SELECT, I_CHANNEL};
        last <= {1'b0, I_REF_LEVEL[0],
          I_REF_OUT && (I_REF_LEVEL != acc_pkg::REF_EXT), I_CONTINUOUS_SELECT, I_CHANNEL};
      end
      else if (I_STOP)
      begin
        bus.ctrl_wdata <= last & ~(8'h01 << acc_pkg::BIT_CONTINUOUS_SELECT);
      end
    end
  end

  // registered view of result and interrupt
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_RESULT <= 11'h000;
      O_IRQ <= 1'b0;
      bus.irq_ack <= 1'b0;
    end
    else
    begin
      O_RESULT <= {bus.res_hi, bus.res_lo[7:5]};
      O_IRQ <= bus.irq;
      bus.irq_ack <= I_ACK;
    end
  end
endmodule

//--- acc_chk_sva.sv
/*
  acc_chk_sva: timing checks on the carrier between the two ends.
  Assumes one clock and the bench's active-low reset.
*/
`timescale 1ns/1ns
module acc_chk (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] res_lo,
  input wire logic irq,
  input wire logic irq_ack
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  logic [12:0] hi_cnt;
  logic [8:0] off_cnt;
  // run lengths; off_cnt saturates so a long idle never wraps
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      hi_cnt <= 13'h0000;
      off_cnt <= 9'h000;
    end
    else
    begin
      hi_cnt <= ctrl_rdata[7] ? hi_cnt + 13'h0001 : 13'h0000;
      if (ctrl_rdata[7] || ctrl_rdata[4])
        off_cnt <= 9'h000;
      else if (off_cnt != 9'h1FF)
        off_cnt <= off_cnt + 9'h001;
    end
  end
  a_low_pad_zero: assert property (res_lo[4:0] == 5'h00)
    else $error("low result bits not zero");
  a_enable_sets: assert property (ctrl_wr && ctrl_wdata[7] |=> ctrl_rdata[7])
    else $error("enable not set by write");
  a_zero_no_effect: assert property (ctrl_wr && !ctrl_wdata[7] && ctrl_rdata[7] |=> ctrl_rdata[7])
    else $error("enable cleared by zero write");
  a_fields_written: assert property (ctrl_wr |=> ctrl_rdata[6:0] == $past(ctrl_wdata[6:0]))
    else $error("control fields not taken");
  a_irq_holds: assert property (irq && !irq_ack |=> irq)
    else $error("pending request lost");
  a_done_raises_irq: assert property ($fell(ctrl_rdata[7]) && !$past(ctrl_wr) |-> irq)
    else $error("no request at completion");
  a_first_conv_len: assert property ($fell(ctrl_rdata[7]) |->
    hi_cnt >= 13'(acc_pkg::FIRST_CONV_CYC))
    else $error("first conversion too short");
  a_no_irq_when_off: assert property ($rose(irq) |-> off_cnt < 9'h12C)
    else $error("request after stop");
  c_continuous_select: cover property (ctrl_wr && ctrl_wdata[4]);
  c_irq: cover property ($rose(irq));
  c_ack: cover property (irq && irq_ack);
endmodule

//--- adc_continuous_conversion_ctrl_tb.sv
/*
  bench: drives the user side of both ends joined by the carrier.
  Assumes design files and checker are compiled first.
*/
`timescale 1ns/1ns
module adc_continuous_conversion_ctrl_tb;
  logic clk, rst_b, start, stop, continuous_select, rout, ack, pwr, rout_en, amode, done, irq_o;
  logic [3:0] ch, ch_o;
  logic [1:0] lvl, lvl_o;
  logic [10:0] smp, res, rslt;
  int fail_count, checks_done, gap, last_gap, dones, n, m;
  logic [31:0] seed;
  acc_if bus ();
  acc_dev u_acc_dev (.I_CLK(clk), .I_RST_B(rst_b), .bus(bus), .I_SAMPLE(smp), .O_PWR_ON(pwr),
    .O_REF_OUT_EN(rout_en), .O_REF_LEVEL(lvl_o), .O_CHANNEL(ch_o), .O_ANALOG_MODE(amode),
    .O_DONE(done));
  acc_sw u_acc_sw (.I_CLK(clk), .I_RST_B(rst_b), .bus(bus), .I_START(start), .I_STOP(stop),
    .I_CONTINUOUS_SELECT(continuous_select), .I_CHANNEL(ch), .I_REF_LEVEL(lvl), .I_REF_OUT(rout), .I_ACK(ack),
    .O_RESULT(rslt), .O_IRQ(irq_o));
  acc_chk u_acc_chk (.I_CLK(clk), .I_RST_B(rst_b), .ctrl_wr(bus.ctrl_wr),
    .ctrl_wdata(bus.ctrl_wdata), .ctrl_rdata(bus.ctrl_rdata), .res_lo(bus.res_lo),
    .irq(bus.irq), .irq_ack(bus.irq_ack));
  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // spacing between completions, for the period check
  always @(posedge clk)
  begin
    last_gap <= done ? gap : last_gap;
    gap <= done ? 1 : gap + 1;
    dones <= dones + int'(done);
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // bus image of a sample: high byte, then three bits on top of the low byte
  function automatic logic [15:0] bytes_of(input logic [10:0] s);
    return {s, 5'h00};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // bounded waits: for the control write, then for completion
  task automatic wait_wr();
    m = 0;
    while (bus.ctrl_wr !== 1'b1 && m < 20)
    begin
      tick(1);
      m++;
    end
    // a limit that runs out is a mismatch
    if (m >= 20) fail_count++;
  endtask
  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 6000)
    begin
      tick(1);
      n++;
    end
    // a stale gap must not pass for a completion that never came
    if (n >= 6000) fail_count++;
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst_b, start, stop, continuous_select, rout, ack, ch, lvl} = '0;
    {gap, dones, fail_count, checks_done} = '0;
    seed = 32'h635F218E;
    smp = 11'h400;
    tick(8);
    rst_b = 1'b1;
    tick(1);
    check({bus.ctrl_rdata, 6'h00, lvl_o}, 16'h0002);
    check({15'h0000, pwr}, 16'h0000);
    ch = 4'(rnd());
    lvl = 2'(rnd() % 3);
    rout = (lvl != 2'h0);
    continuous_select = 1'b1;
    pulse(start);
    wait_wr();
    tick(20);
    check({4'h0, ch_o, lvl_o, rout_en, amode, pwr, 3'h0}, {4'h0, ch, lvl, rout, 5'h18});
    wait_done();
    check(16'(n >= 5149 && n <= 5152), 16'h0001);
    for (int k = 0; k < 6; k++)
    begin
      res = smp;
      smp = (k == 0) ? 11'h3FF : 11'(rnd());
      tick(4);
      check({bus.res_hi, bus.res_lo}, bytes_of(res));
      check({5'h00, rslt}, {5'h00, res});
      check({13'h0000, bus.ctrl_rdata[7], bus.irq, irq_o}, 16'h0003);
      if (k < 5)
      begin
        pulse(ack);
        wait_done();
        // the gap counter takes the completion one edge later
        tick(1);
        check(16'(last_gap), 16'h0100);
      end
    end
    continuous_select = 1'b0;
    pulse(stop);
    m = dones;
    tick(700);
    check(16'(dones - m <= 1), 16'h0001);
    check({14'h0000, bus.irq, pwr}, 16'h0002);
    pulse(ack);
    tick(3);
    check({15'h0000, bus.irq}, 16'h0000);
    // single shot, restarted part way, with a zero-enable write meanwhile
    smp = 11'(rnd());
    pulse(start);
    wait_wr();
    tick(100);
    pulse(start);
    wait_wr();
    tick(50);
    pulse(stop);
    wait_done();
    check(16'(n >= 5077 && n <= 5080), 16'h0001);
    tick(4);
    check({bus.res_hi, bus.res_lo}, bytes_of(smp));
    check({14'h0000, bus.ctrl_rdata[7], amode}, 16'h0000);
    m = dones;
    tick(600);
    check(16'(dones - m), 16'h0000);
    give_verdict();
  end
  // watchdog, well beyond the expected run of some 13000 cycles
  initial
  begin
    #400000;
    fail_count++;
    give_verdict();
  end
endmodule
